// file: alu_core.sv
// Arithmetic and logic datapath with bit operations on the low I/O space.
// Assumes an AHB-Lite master with single word transfers; hardware flag set pulses are synchronous.
`timescale 1ns/10ps
module alu_core (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [alu_pkg::BUS_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [alu_pkg::BUS_W-1:0] hwdata,
    input wire logic hready,
    input wire logic [alu_pkg::BYTE_W-1:0] io_flag_set,
    output logic hreadyout,
    output logic hresp,
    output logic [alu_pkg::BUS_W-1:0] hrdata,
    output logic [alu_pkg::BYTE_W-1:0] status_flags,
    output logic skip_taken
);
    import alu_pkg::*;

    // =====================================================
    // Decoding helpers
    // =====================================================
    function automatic logic is_word_op(input logic [OP_W-1:0] op);
        return (op == OP_WORD_ADD_IMMEDIATE) || (op == OP_WORD_SUBTRACT_IMMEDIATE);
    endfunction : is_word_op

    function automatic logic is_io_op(input logic [OP_W-1:0] op);
        return (op == OP_SET_IO_BIT) || (op == OP_CLEAR_IO_BIT) ||
               (op == OP_SKIP_IF_IO_BIT_SET) || (op == OP_SKIP_IF_IO_BIT_CLEAR);
    endfunction : is_io_op

    function automatic logic [BYTE_W-1:0] bit_mask(input logic [BIT_SEL_W-1:0] sel);
        return 8'h01 << sel;
    endfunction : bit_mask

    // =====================================================
    // Declarations
    // =====================================================
    bus_state_e bus_state;
    engine_state_e eng_state;
    logic [7:0] dp_addr;
    logic dp_write;
    logic [7:0] dest_low;
    logic [7:0] dest_high;
    logic [7:0] source;
    logic [31:0] command;
    logic [7:0] word_low;
    logic word_carry;
    logic word_sub;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [BIT_SEL_W-1:0] io_bit;
    logic [OP_W-1:0] io_op;
    logic [7:0] io_flags;
    logic [7:0] flag_snapshot;
    logic flag_sel;
    logic [7:0] ram_rdata;
    logic ram_we;
    logic [IO_ADDR_W-1:0] ram_waddr;
    logic [7:0] ram_wdata;
    logic [IO_ADDR_W-1:0] ram_raddr;
    logic [7:0] io_read_value;
    logic [7:0] io_modified;
    logic io_bit_value;
    logic engine_idle;
    logic accept;
    logic bus_go;
    logic wr_go;
    logic io_bus_write;
    logic cmd_launch;
    logic [OP_W-1:0] new_op;
    logic [IO_ADDR_W-1:0] new_io_addr;
    logic [BIT_SEL_W-1:0] new_io_bit;
    logic [31:0] read_word;
    logic [7:0] flag_clear;
    logic use_carry;
    logic carry_in;
    logic [8:0] sum9;
    logic [8:0] diff9;
    logic [7:0] next_result;
    logic [7:0] next_flags;
    logic result_we;
    logic [7:0] word_high;
    logic [15:0] word_res;
    logic [7:0] word_flags;

    // =====================================================
    // Bus decode
    // =====================================================
    assign engine_idle = (eng_state == ENG_IDLE);
    assign accept = hsel && htrans[1] && hready;
    assign bus_go = (bus_state == BUS_WAIT) && engine_idle;
    assign wr_go = bus_go && dp_write;
    assign io_bus_write = wr_go && dp_addr[IO_WINDOW_BIT];
    assign cmd_launch = wr_go && (dp_addr == ADDR_COMMAND);
    assign new_op = hwdata[CMD_OP_LSB +: OP_W];
    // Five address bits cannot name anything above 0x1F
    assign new_io_addr = hwdata[CMD_IO_LSB +: IO_ADDR_W];
    assign new_io_bit = hwdata[CMD_BIT_LSB +: BIT_SEL_W];

    always_comb begin
        read_word = WORD_RESET;
        case (dp_addr)
            ADDR_DEST_LOW: read_word[7:0] = dest_low;
            ADDR_DEST_HIGH: read_word[7:0] = dest_high;
            ADDR_SOURCE: read_word[7:0] = source;
            ADDR_FLAGS: read_word[7:0] = status_flags;
            ADDR_COMMAND: read_word = command;
            ADDR_ENGINE: begin
                read_word[ENG_BUSY_BIT] = !engine_idle;
                read_word[ENG_SKIP_BIT] = skip_taken;
            end
            default: read_word = WORD_RESET;
        endcase
    end

    // =====================================================
    // AHB-Lite slave; every data phase waits for an idle engine
    // =====================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= BUS_IDLE;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= WORD_RESET;
            dp_addr <= BYTE_RESET;
            dp_write <= 1'b0;
        end else begin
            case (bus_state)
                BUS_IDLE, BUS_DONE: begin
                    if (accept) begin
                        dp_addr <= haddr[7:0];
                        dp_write <= hwrite;
                        hreadyout <= 1'b0;
                        bus_state <= BUS_WAIT;
                    end else begin
                        bus_state <= BUS_IDLE;
                    end
                end
                BUS_WAIT: begin
                    if (engine_idle) begin
                        if (dp_write) begin
                            hreadyout <= 1'b1;
                            bus_state <= BUS_DONE;
                        end else if (dp_addr[IO_WINDOW_BIT]) begin
                            bus_state <= BUS_IO;
                        end else begin
                            hrdata <= read_word;
                            hreadyout <= 1'b1;
                            bus_state <= BUS_DONE;
                        end
                    end
                end
                BUS_IO: begin
                    hrdata <= {24'h000000, io_read_value};
                    hreadyout <= 1'b1;
                    bus_state <= BUS_DONE;
                end
                default: begin
                    bus_state <= BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // =====================================================
    // Byte ALU for one-cycle operations
    // =====================================================
    always_comb begin
        use_carry = (new_op == OP_ADD_WITH_CARRY) || (new_op == OP_SUBTRACT_WITH_CARRY) ||
                    (new_op == OP_SUBTRACT_WITH_CARRY_IMMEDIATE);
        carry_in = use_carry && status_flags[FLAG_C];
        sum9 = {1'b0, dest_low} + {1'b0, source} + {8'h00, carry_in};
        diff9 = {1'b0, dest_low} - {1'b0, source} - {8'h00, carry_in};
        next_result = dest_low;
        next_flags = status_flags;
        result_we = 1'b0;
        case (new_op)
            OP_ADD, OP_ADD_WITH_CARRY: begin
                next_result = sum9[7:0];
                next_flags[FLAG_C] = sum9[8];
                next_flags[FLAG_H] = dest_low[4] ^ source[4] ^ sum9[4];
                next_flags[FLAG_V] = (dest_low[7] == source[7]) && (sum9[7] != dest_low[7]);
                next_flags[FLAG_N] = sum9[7];
                next_flags[FLAG_Z] = (sum9[7:0] == BYTE_RESET);
                result_we = 1'b1;
            end
            OP_SUBTRACT, OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_WITH_CARRY,
            OP_SUBTRACT_WITH_CARRY_IMMEDIATE: begin
                next_result = diff9[7:0];
                next_flags[FLAG_C] = diff9[8];
                next_flags[FLAG_H] = dest_low[4] ^ source[4] ^ diff9[4];
                next_flags[FLAG_V] = (dest_low[7] != source[7]) && (diff9[7] != dest_low[7]);
                next_flags[FLAG_N] = diff9[7];
                // Carry forms chain zero across bytes of a wider compare
                next_flags[FLAG_Z] = (diff9[7:0] == BYTE_RESET) &&
                                     (!use_carry || status_flags[FLAG_Z]);
                result_we = 1'b1;
            end
            OP_AND, OP_AND_IMMEDIATE: begin
                next_result = dest_low & source;
                result_we = 1'b1;
            end
            OP_OR, OP_OR_IMMEDIATE, OP_EXCLUSIVE_OR: begin
                next_result = (new_op == OP_EXCLUSIVE_OR) ? (dest_low ^ source) : (dest_low | source);
                result_we = 1'b1;
            end
            OP_SET_MASK_BITS: begin
                next_result = dest_low | source;
                result_we = 1'b1;
            end
            OP_CLEAR_MASK_BITS: begin
                next_result = dest_low & (FULL_MASK - source);
                result_we = 1'b1;
            end
            default: begin
                result_we = 1'b0;
            end
        endcase
        if (result_we && (new_op >= OP_AND)) begin
            next_flags[FLAG_V] = 1'b0;
            next_flags[FLAG_N] = next_result[7];
            next_flags[FLAG_Z] = (next_result == BYTE_RESET);
        end
    end

    // =====================================================
    // Word ALU, high byte in the second cycle
    // =====================================================
    always_comb begin
        word_high = word_sub ? (dest_high - {7'h00, word_carry}) : (dest_high + {7'h00, word_carry});
        word_res = {word_high, word_low};
        word_flags = status_flags;
        word_flags[FLAG_N] = word_res[15];
        word_flags[FLAG_Z] = (word_res == 16'h0000);
        word_flags[FLAG_V] = word_sub ? (dest_high[7] && !word_res[15]) : (!dest_high[7] && word_res[15]);
        word_flags[FLAG_C] = word_sub ? (word_res[15] && !dest_high[7]) : (!word_res[15] && dest_high[7]);
        word_flags[FLAG_S] = word_flags[FLAG_N] ^ word_flags[FLAG_V];
    end

    // =====================================================
    // Operand and status registers
    // =====================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dest_low <= BYTE_RESET;
            dest_high <= BYTE_RESET;
            source <= BYTE_RESET;
            status_flags <= BYTE_RESET;
        end else if (eng_state == ENG_WORD_HIGH) begin
            dest_low <= word_low;
            dest_high <= word_high;
            status_flags <= word_flags;
        end else if (cmd_launch && result_we) begin
            dest_low <= next_result;
            status_flags <= next_flags;
        end else if (wr_go) begin
            case (dp_addr)
                ADDR_DEST_LOW: dest_low <= hwdata[7:0];
                ADDR_DEST_HIGH: dest_high <= hwdata[7:0];
                ADDR_SOURCE: source <= hwdata[7:0];
                ADDR_FLAGS: status_flags <= hwdata[7:0];
                default: source <= source;
            endcase
        end
    end

    // =====================================================
    // Sequencer for two-cycle operations
    // =====================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eng_state <= ENG_IDLE;
            command <= WORD_RESET;
            word_low <= BYTE_RESET;
            word_carry <= 1'b0;
            word_sub <= 1'b0;
            io_addr <= '0;
            io_bit <= '0;
            io_op <= '0;
            skip_taken <= 1'b0;
        end else begin
            case (eng_state)
                ENG_IDLE: begin
                    if (cmd_launch) begin
                        command <= hwdata;
                        skip_taken <= 1'b0;
                        if (is_word_op(new_op)) begin
                            word_sub <= (new_op == OP_WORD_SUBTRACT_IMMEDIATE);
                            word_low <= (new_op == OP_WORD_SUBTRACT_IMMEDIATE) ? diff9[7:0] : sum9[7:0];
                            word_carry <= (new_op == OP_WORD_SUBTRACT_IMMEDIATE) ? diff9[8] : sum9[8];
                            eng_state <= ENG_WORD_HIGH;
                        end else if (is_io_op(new_op)) begin
                            io_addr <= new_io_addr;
                            io_bit <= new_io_bit;
                            io_op <= new_op;
                            eng_state <= ENG_IO_MODIFY;
                        end
                    end
                end
                ENG_WORD_HIGH: begin
                    eng_state <= ENG_IDLE;
                end
                ENG_IO_MODIFY: begin
                    if (io_op == OP_SKIP_IF_IO_BIT_SET) begin
                        skip_taken <= io_bit_value;
                    end else if (io_op == OP_SKIP_IF_IO_BIT_CLEAR) begin
                        skip_taken <= !io_bit_value;
                    end
                    eng_state <= ENG_IDLE;
                end
                default: begin
                    eng_state <= ENG_IDLE;
                end
            endcase
        end
    end

    // =====================================================
    // I/O space: byte store plus one write-one-to-clear flag register
    // =====================================================
    assign io_read_value = flag_sel ? flag_snapshot : ram_rdata;
    assign io_bit_value = io_read_value[io_bit];
    // Read-modify-write rewrites the other bits with the value just read
    assign io_modified = (io_op == OP_SET_IO_BIT) ? (io_read_value | bit_mask(io_bit)) :
                         (io_read_value & ~bit_mask(io_bit));
    assign ram_raddr = cmd_launch ? new_io_addr : dp_addr[6:2];

    always_comb begin
        ram_we = 1'b0;
        ram_waddr = io_addr;
        ram_wdata = io_modified;
        if ((eng_state == ENG_IO_MODIFY) && (io_addr != IO_FLAG_ADDR) &&
            ((io_op == OP_SET_IO_BIT) || (io_op == OP_CLEAR_IO_BIT))) begin
            ram_we = 1'b1;
        end else if (io_bus_write && (dp_addr[6:2] != IO_FLAG_ADDR)) begin
            ram_we = 1'b1;
            ram_waddr = dp_addr[6:2];
            ram_wdata = hwdata[7:0];
        end
    end

    // Only a one in the addressed bit reaches the flags, so a bit clear never touches them
    always_comb begin
        flag_clear = BYTE_RESET;
        if (io_bus_write && (dp_addr[6:2] == IO_FLAG_ADDR)) begin
            flag_clear = hwdata[7:0];
        end else if ((eng_state == ENG_IO_MODIFY) && (io_op == OP_SET_IO_BIT) && (io_addr == IO_FLAG_ADDR)) begin
            flag_clear = bit_mask(io_bit);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_flags <= BYTE_RESET;
            flag_snapshot <= BYTE_RESET;
            flag_sel <= 1'b0;
        end else begin
            // A hardware set in the same cycle as a clear wins
            io_flags <= (io_flags & ~flag_clear) | io_flag_set;
            flag_snapshot <= io_flags;
            flag_sel <= (ram_raddr == IO_FLAG_ADDR);
        end
    end

    io_bit_ram u_io_bit_ram (
        .clk(hclk),
        .write_en(ram_we),
        .write_addr(ram_waddr),
        .write_data(ram_wdata),
        .read_addr(ram_raddr),
        .read_data(ram_rdata)
    );
endmodule : alu_core

// file: alu_pkg.sv
// Constants, opcodes and state types shared by the ALU datapath and its I/O store.
// Assumes a single 125 MHz core clock and an AHB-Lite register bus with 32-bit data.
package alu_pkg;
    // =====================================================
    // Widths
    // =====================================================
    localparam int unsigned BUS_W = 32;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned IO_ADDR_W = 5;
    localparam int unsigned IO_DEPTH = 32;
    localparam int unsigned BIT_SEL_W = 3;
    localparam int unsigned OP_W = 5;

    // =====================================================
    // Register map (byte addresses, low eight address bits decoded)
    // =====================================================
    localparam logic [7:0] ADDR_DEST_LOW = 8'h00;
    localparam logic [7:0] ADDR_DEST_HIGH = 8'h04;
    localparam logic [7:0] ADDR_SOURCE = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_COMMAND = 8'h10;
    localparam logic [7:0] ADDR_ENGINE = 8'h14;
    localparam int unsigned IO_WINDOW_BIT = 7;

    // =====================================================
    // Field positions
    // =====================================================
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_IO_LSB = 8;
    localparam int unsigned CMD_BIT_LSB = 16;
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned ENG_BUSY_BIT = 0;
    localparam int unsigned ENG_SKIP_BIT = 1;

    // =====================================================
    // Reset values and fixed values
    // =====================================================
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [7:0] FULL_MASK = 8'hff;
    localparam logic [4:0] IO_FLAG_ADDR = 5'h08;

    // =====================================================
    // Opcodes
    // =====================================================
    localparam logic [4:0] OP_ADD = 5'h00;
    localparam logic [4:0] OP_ADD_WITH_CARRY = 5'h01;
    localparam logic [4:0] OP_WORD_ADD_IMMEDIATE = 5'h02;
    localparam logic [4:0] OP_SUBTRACT = 5'h03;
    localparam logic [4:0] OP_SUBTRACT_IMMEDIATE = 5'h04;
    localparam logic [4:0] OP_SUBTRACT_WITH_CARRY = 5'h05;
    localparam logic [4:0] OP_SUBTRACT_WITH_CARRY_IMMEDIATE = 5'h06;
    localparam logic [4:0] OP_WORD_SUBTRACT_IMMEDIATE = 5'h07;
    localparam logic [4:0] OP_AND = 5'h08;
    localparam logic [4:0] OP_AND_IMMEDIATE = 5'h09;
    localparam logic [4:0] OP_OR = 5'h0a;
    localparam logic [4:0] OP_OR_IMMEDIATE = 5'h0b;
    localparam logic [4:0] OP_EXCLUSIVE_OR = 5'h0c;
    localparam logic [4:0] OP_SET_MASK_BITS = 5'h0d;
    localparam logic [4:0] OP_CLEAR_MASK_BITS = 5'h0e;
    localparam logic [4:0] OP_SET_IO_BIT = 5'h10;
    localparam logic [4:0] OP_CLEAR_IO_BIT = 5'h11;
    localparam logic [4:0] OP_SKIP_IF_IO_BIT_SET = 5'h12;
    localparam logic [4:0] OP_SKIP_IF_IO_BIT_CLEAR = 5'h13;

    // =====================================================
    // State types
    // =====================================================
    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_WORD_HIGH = 3'b010,
        ENG_IO_MODIFY = 3'b100
    } engine_state_e;

    typedef enum logic [3:0] {
        BUS_IDLE = 4'b0001,
        BUS_WAIT = 4'b0010,
        BUS_IO = 4'b0100,
        BUS_DONE = 4'b1000
    } bus_state_e;
endpackage : alu_pkg

// file: io_bit_ram.sv
// Byte store for the bit-accessible I/O locations.
// Assumes one writer and one reader per cycle; read data are registered, no reset.
`timescale 1ns/10ps
module io_bit_ram (
    input wire logic clk,
    input wire logic write_en,
    input wire logic [alu_pkg::IO_ADDR_W-1:0] write_addr,
    input wire logic [alu_pkg::BYTE_W-1:0] write_data,
    input wire logic [alu_pkg::IO_ADDR_W-1:0] read_addr,
    output logic [alu_pkg::BYTE_W-1:0] read_data
);
    import alu_pkg::*;

    logic [BYTE_W-1:0] mem [IO_DEPTH];

    // =====================================================
    // Storage
    // =====================================================
    always_ff @(posedge clk) begin
        if (write_en) begin
            mem[write_addr] <= write_data;
        end
        read_data <= mem[read_addr];
    end
endmodule : io_bit_ram

// file: alu_core_checker.sv
// Assertions on alu_core bus answers and on what may change the flags.
// Assumes hready is fed back from hreadyout.
`timescale 1ns/10ps
module alu_core_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] status_flags,
    input wire logic skip_taken
);
    // =====================================
    // Data phase tracking
    logic pend;
    logic ph_wr;
    logic [7:0] ph_addr;
    wire acc = hsel & htrans[1] & hready;
    wire rd_ph = pend & ~ph_wr;
    wire cmd_ph = pend & ph_wr & ph_addr == 8'h10;
    wire flag_ph = pend & ph_wr & ph_addr == 8'h0c;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) pend <= 1'b0;
        else if (acc) pend <= 1'b1;
        else if (hreadyout) pend <= 1'b0;
    // Left unreset: only used while pend is high
    always_ff @(posedge hclk) begin
        if (acc) begin
            ph_addr <= haddr[7:0];
            ph_wr <= hwrite;
        end
    end
    // =====================================
    // Properties
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_answer;
        !hreadyout ##[1:3] hreadyout;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
    a_answer_bound: assert property (acc |=> s_answer) else $error("answer late");
    a_stall_cause: assert property (!hreadyout |-> $past(acc) || !$past(hreadyout)) else $error("stray stall");
    a_idle_ready: assert property (!pend |-> hreadyout) else $error("stall when idle");
    a_rdata_load: assert property ($changed(hrdata) |-> hreadyout && $past(rd_ph)) else $error("hrdata moved");
    a_flags_cause: assert property ($changed(status_flags) |-> $past(cmd_ph) || $past(cmd_ph, 2)
        || $past(flag_ph)) else $error("flags moved");
    a_flags_top: assert property ($changed(status_flags[7:6]) |-> $past(flag_ph)) else $error("top flags");
    a_skip_cause: assert property ($changed(skip_taken) |-> $past(cmd_ph) || $past(cmd_ph, 2))
        else $error("skip moved");
endmodule : alu_core_checker
bind alu_core alu_core_checker i_chk (.*);

// file: flag_source.sv
// Hardware side that raises flags in the write-one-to-clear I/O register.
// Assumes a one-cycle fire strobe from the bench.
`timescale 1ns/10ps
module flag_source (
    input wire logic hclk,
    input wire logic fire,
    input wire logic [7:0] pattern,
    output logic [7:0] io_flag_set
);
    // =====================================
    // Set pulse
    initial io_flag_set = 8'h00;
    always @(posedge hclk) io_flag_set <= fire ? pattern : 8'h00;
endmodule : flag_source

// file: tb.sv
// Self-checking bench for alu_core; reads are compared with queued expectations.
// Assumes hready is fed back from hreadyout.
`timescale 1ns/10ps
module tb;
    import alu_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, rd_ph = 0, fire = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [7:0] io_flag_set, status_flags, pat = 0, a, b, f, r;
    logic hreadyout, hresp, skip_taken;
    logic [31:0] exq[$];
    int num_errors = 0, checked = 0;
    integer seed = 32'hb785b18d;
    alu_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .io_flag_set(io_flag_set),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .status_flags(status_flags),
        .skip_taken(skip_taken));
    flag_source i_src (.hclk(hclk), .fire(fire), .pattern(pat), .io_flag_set(io_flag_set));
    initial forever #4 hclk = ~hclk;
    // =====================================
    // Tasks
    task chk(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wrap_up;
        $display("Errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
        haddr <= {24'h0, ad};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph <= ~w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask : xfer
    task wr(input logic [7:0] ad, input logic [31:0] d);
        xfer(1'b1, ad, d);
    endtask : wr
    task rd(input logic [7:0] ad, input logic [31:0] e);
        exq.push_back(e);
        xfer(1'b0, ad, 32'h0);
    endtask : rd
    task cmd(input logic [4:0] o, lc, input logic [2:0] bt);
        wr(8'h10, {13'h0, bt, 3'h0, lc, 3'h0, o});
    endtask : cmd
    task op(input logic [4:0] o, input logic [7:0] dl, dh, k, fi, el, eh, ef);
        logic [7:0] v[5];
        v = '{dl, dh, k, fi, 8'(o)};
        for (int i = 0; i < 5; i++) wr(8'(4 * i), 32'(v[i]));
        v = '{el, eh, ef, 8'h00, 8'h00};
        for (int i = 0; i < 3; i++) rd(i == 2 ? 8'h0c : 8'(4 * i), 32'(v[i]));
        chk(32'(status_flags), 32'(ef));
    endtask : op
    always @(posedge hclk) if (rd_ph && hreadyout === 1'b1) chk(hrdata, exq.pop_front());
    initial begin
        #50000;
        num_errors++;
        wrap_up();
    end
    // =====================================
    // Sequence
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        op(OP_ADD, 8'h7f, 8'h00, 8'h01, 8'h10, 8'h80, 8'h00, 8'h3c);
        op(OP_ADD_WITH_CARRY, 8'hff, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h23);
        op(OP_WORD_ADD_IMMEDIATE, 8'hff, 8'h7f, 8'h01, 8'h20, 8'h00, 8'h80, 8'h2c);
        op(OP_SUBTRACT, 8'h10, 8'h00, 8'h01, 8'h00, 8'h0f, 8'h00, 8'h20);
        op(OP_SUBTRACT_IMMEDIATE, 8'h00, 8'h00, 8'h01, 8'h00, 8'hff, 8'h00, 8'h25);
        op(OP_SUBTRACT_WITH_CARRY, 8'h05, 8'h00, 8'h05, 8'h02, 8'h00, 8'h00, 8'h02);
        op(OP_SUBTRACT_WITH_CARRY_IMMEDIATE, 8'h80, 8'h00, 8'h00, 8'h01, 8'h7f, 8'h00, 8'h28);
        op(OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 8'h00, 8'h01, 8'h20, 8'hff, 8'hff, 8'h35);
        op(OP_CLEAR_MASK_BITS, 8'hff, 8'h00, 8'h0f, 8'h08, 8'hf0, 8'h00, 8'h04);
        for (int i = 0; i < 6; i++) begin
            a = 8'($random(seed));
            b = 8'($random(seed));
            f = 8'($random(seed));
            r = (i < 2) ? a & b : (i == 4) ? a ^ b : a | b;
            op(OP_AND + 5'(i), a, 8'h00, b, f, r, 8'h00, f & 8'hf1 | {5'h0, r[7], r == 8'h00, 1'b0});
        end
        wr(8'h8c, 32'h0000_00a5);
        wr(8'h0c, 32'h0000_002a);
        cmd(OP_SET_IO_BIT, 5'd3, 3'd1);
        rd(8'h8c, 32'h0000_00a7);
        cmd(OP_CLEAR_IO_BIT, 5'd3, 3'd0);
        rd(8'h8c, 32'h0000_00a6);
        cmd(OP_SKIP_IF_IO_BIT_SET, 5'd3, 3'd1);
        rd(8'h14, 32'h0000_0002);
        cmd(OP_SKIP_IF_IO_BIT_CLEAR, 5'd3, 3'd1);
        rd(8'h14, 32'h0000_0000);
        cmd(OP_SKIP_IF_IO_BIT_CLEAR, 5'd3, 3'd0);
        rd(8'h14, 32'h0000_0002);
        chk(32'(skip_taken), 32'h0000_0001);
        rd(8'h0c, 32'h0000_002a);
        rd(8'h40, 32'h0000_0000);
        pat <= 8'($random(seed)) | 8'h01;
        fire <= 1'b1;
        @(posedge hclk);
        fire <= 1'b0;
        @(posedge hclk);
        rd(8'ha0, 32'(pat));
        cmd(OP_SET_IO_BIT, 5'd8, 3'd0);
        rd(8'ha0, 32'(pat & 8'hfe));
        cmd(OP_CLEAR_IO_BIT, 5'd8, 3'd7);
        rd(8'ha0, 32'(pat & 8'hfe));
        wr(8'ha0, 32'h0000_00ff);
        rd(8'ha0, 32'h0000_0000);
        @(posedge hclk);
        wrap_up();
    end
endmodule : tb
